// ==== core/clcdp_consts.svh ====
`ifndef CLCDP_CONSTS_SVH
`define CLCDP_CONSTS_SVH
// clock and timing figures
`define CLCDP_CLK_KHZ 10000
`define CLCDP_POR_MS 40
`define CLCDP_CLEAR_MS 2
`define CLCDP_EXEC_US 30
// instruction opcodes, compared against the upper bits of the byte
`define CLCDP_OP_CLEAR 8'h01
`define CLCDP_OP_ENTRY 6'h01
`define CLCDP_OP_DISP 5'h01
`define CLCDP_OP_FUNC 3'h1
`define CLCDP_OP_DDRAM 1'h1
`define CLCDP_OP_OSC 4'h1
`define CLCDP_OP_POWER 4'h5
`define CLCDP_OP_FOLLOW 4'h6
`define CLCDP_OP_CONTR 4'h7
// defaults loaded by the power-on initialisation
`define CLCDP_RST_OSC 3'h4
`define CLCDP_RST_CONTRAST 6'h20
`define CLCDP_RST_RATIO 3'h2
// bus mode strap codes
`define CLCDP_MODE_PAR 2'h0
`define CLCDP_MODE_SER 2'h1
// width of the busy-time counter
`define CLCDP_CNT_W 20
// serial bits per byte
`define CLCDP_SER_BITS 4'h8
`endif

// ==== core/clcdp_pkg.sv ====
package clcdp_pkg;
  typedef logic [5:0] clcdp_contrast_t;
  typedef logic [2:0] clcdp_ratio_t;
  typedef logic [2:0] clcdp_osc_t;
  typedef logic [6:0] clcdp_addr_t;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_EXEC} clcdp_state_t;
endpackage

// ==== core/clcdp_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clcdp_consts.svh"
module clcdp_host_port #(
  parameter int POR_CYCLES = `CLCDP_POR_MS * `CLCDP_CLK_KHZ,
  parameter int CLEAR_CYCLES = `CLCDP_CLEAR_MS * `CLCDP_CLK_KHZ,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ext_reset_pin_n,
  input wire logic option_strap_one,
  input wire logic option_strap_two,
  input wire logic [1:0] bus_mode,
  input wire logic chip_select_low,
  input wire logic e_strobe,
  input wire logic register_select,
  input wire logic read_write,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic [7:0] db_oe,
  output logic busy_flag,
  output clcdp_pkg::clcdp_addr_t address_counter,
  output logic bus_width_select,
  output logic line_count_select,
  output logic tall_font_select,
  output logic instr_table_select,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic entry_increment,
  output logic entry_shift,
  output logic clear_display,
  output clcdp_pkg::clcdp_osc_t osc_adjust_field,
  output logic bias_select,
  output logic icon_on,
  output logic booster_on,
  output logic follower_on,
  output clcdp_pkg::clcdp_contrast_t contrast_value,
  output clcdp_pkg::clcdp_ratio_t amp_ratio_field
);
  import clcdp_pkg::*;

  localparam int EXEC_CYCLES = (`CLCDP_EXEC_US * `CLCDP_CLK_KHZ) / 1000;
  localparam int FW = 9;
  localparam int PW = $clog2(FIFO_DEPTH);

  initial
  begin
    if (POR_CYCLES < 1 || POR_CYCLES >= (1 << `CLCDP_CNT_W))
      $error("POR_CYCLES out of range");
    if (CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << `CLCDP_CNT_W))
      $error("CLEAR_CYCLES out of range");
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
      $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  // next address after a data write, steered by the entry mode
  function automatic clcdp_addr_t ac_step(input clcdp_addr_t a, input logic inc);
    ac_step = inc ? a + 7'h01 : a - 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = 15;
  logic [SW-1:0] raw_w;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic e_d_q;
  logic scl_d_q;
  logic [1:0] mode_s1_q;
  logic [1:0] mode_q;

  assign raw_w = {ext_reset_pin_n, option_strap_one, option_strap_two, chip_select_low,
                  e_strobe, register_select, read_write, db_in};

  // two stages; everything downstream reads only the second
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // strobe bit resets low, its idle level, so no false edge follows reset
      sync1_q <= 15'h7BFF;
      sync2_q <= 15'h7BFF;
      e_d_q <= 1'b0;
      scl_d_q <= 1'b1;
      mode_s1_q <= `CLCDP_MODE_PAR;
      mode_q <= `CLCDP_MODE_PAR;
    end
    else
    begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      e_d_q <= sync2_q[10];
      scl_d_q <= sync2_q[7];
      mode_s1_q <= bus_mode; // static strap, but still a pin: two stages
      mode_q <= mode_s1_q;
    end
  end

  logic xrst_n_s, straps_low, csb_s, e_s, rs_s, rw_s;
  logic [7:0] db_s;
  assign xrst_n_s = sync2_q[14];
  // both straps low select the internal follower
  assign straps_low = ~sync2_q[13] & ~sync2_q[12];
  assign csb_s = sync2_q[11];
  assign e_s = sync2_q[10];
  assign rs_s = sync2_q[9];
  assign rw_s = sync2_q[8];
  assign db_s = sync2_q[7:0];

  logic e_fall, e_rise, scl_rise, par_mode, ser_mode;
  assign e_fall = e_d_q & ~e_s;
  assign e_rise = ~e_d_q & e_s;
  assign scl_rise = ~scl_d_q & db_s[7];
  assign par_mode = (mode_q == `CLCDP_MODE_PAR);
  assign ser_mode = (mode_q == `CLCDP_MODE_SER);

  ////////////////////////////////////////////////////////////////////
  // parallel and serial framing into a pending word {rs, byte}
  logic nib_phase_q;
  logic [3:0] nib_hi_q;
  logic [3:0] ser_cnt_q;
  logic [7:0] ser_sh_q;
  logic pend_valid_q;
  logic [FW-1:0] pend_q;
  logic fifo_ready;
  logic word_done;
  logic [FW-1:0] word_val;
  clcdp_state_t state_q;

  always_comb
  begin
    word_done = 1'b0;
    word_val = {rs_s, db_s};
    if (par_mode && e_fall && !rw_s)
    begin
      if (bus_width_select)
        word_done = 1'b1;
      else
      begin
        word_done = nib_phase_q;
        word_val = {rs_s, nib_hi_q, db_s[7:4]};
      end
    end
    else if (ser_mode && !csb_s && scl_rise && ser_cnt_q == `CLCDP_SER_BITS - 4'h1)
    begin
      word_done = 1'b1;
      word_val = {rs_s, ser_sh_q[6:0], db_s[6]};
    end
  end

  // nibble pairing; reads and writes share the phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nib_phase_q <= 1'b0;
      nib_hi_q <= 4'h0;
    end
    else if (!xrst_n_s || bus_width_select || state_q == ST_INIT)
      nib_phase_q <= 1'b0;
    else if (par_mode && e_fall)
    begin
      nib_phase_q <= ~nib_phase_q;
      if (!nib_phase_q)
        nib_hi_q <= db_s[7:4];
    end
  end

  // serial shifter, msb first, bit count cleared while chip select is high
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_cnt_q <= 4'h0;
      ser_sh_q <= 8'h00;
    end
    else if (csb_s || !ser_mode)
      ser_cnt_q <= 4'h0;
    else if (scl_rise)
    begin
      ser_sh_q <= {ser_sh_q[6:0], db_s[6]};
      ser_cnt_q <= word_done ? 4'h0 : ser_cnt_q + 4'h1;
    end
  end

  // pending holding word; a word arriving while it and the buffer are both full is lost
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_valid_q <= 1'b0;
      pend_q <= 9'h000;
    end
    else if (!xrst_n_s || state_q == ST_INIT)
      pend_valid_q <= 1'b0;
    else if (word_done && (!pend_valid_q || fifo_ready))
    begin
      pend_valid_q <= 1'b1;
      pend_q <= word_val;
    end
    else if (fifo_ready)
      pend_valid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // two-entry buffer between framing and execution
  logic [FW-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW:0] wr_ptr_q;
  logic [PW:0] rd_ptr_q;
  logic fifo_full, fifo_empty, fifo_pop;
  assign fifo_empty = (wr_ptr_q == rd_ptr_q);
  assign fifo_full = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
  assign fifo_ready = ~fifo_full & pend_valid_q;
  // execution drains only while idle, so a slow instruction stalls the source
  assign fifo_pop = ~fifo_empty & (state_q == ST_IDLE);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else if (!xrst_n_s || state_q == ST_INIT)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (fifo_ready)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (fifo_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (fifo_ready)
      fifo_mem[wr_ptr_q[PW-1:0]] <= pend_q;
  end

  logic [FW-1:0] head;
  logic [7:0] hb;
  assign head = fifo_mem[rd_ptr_q[PW-1:0]];
  assign hb = head[7:0];

  ////////////////////////////////////////////////////////////////////
  // busy sequencing: power-on wait, idle, instruction execution
  logic [`CLCDP_CNT_W-1:0] cnt_q;
  logic is_clear;
  assign is_clear = ~head[8] & (hb == `CLCDP_OP_CLEAR);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_INIT;
      cnt_q <= '0;
    end
    else if (!xrst_n_s)
    begin
      state_q <= ST_INIT;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_INIT:
        begin
          if (cnt_q == `CLCDP_CNT_W'(POR_CYCLES - 1))
          begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_IDLE:
        begin
          if (fifo_pop)
          begin
            state_q <= ST_EXEC;
            cnt_q <= is_clear ? `CLCDP_CNT_W'(CLEAR_CYCLES - 1) : `CLCDP_CNT_W'(EXEC_CYCLES - 1);
          end
        end
        ST_EXEC:
        begin
          if (cnt_q == '0)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default:
          state_q <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_flag <= 1'b1;
    else
      busy_flag <= (state_q != ST_IDLE) | fifo_pop | ~fifo_empty | pend_valid_q | word_done;
  end

  ////////////////////////////////////////////////////////////////////
  // instruction decode and configuration state
  logic ext_ok;
  assign ext_ok = fifo_pop & ~head[8] & instr_table_select;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_width_select <= 1'b1;
      line_count_select <= 1'b0;
      tall_font_select <= 1'b0;
      instr_table_select <= 1'b0;
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      entry_increment <= 1'b1;
      entry_shift <= 1'b0;
      osc_adjust_field <= `CLCDP_RST_OSC;
      bias_select <= 1'b0;
      icon_on <= 1'b0;
      booster_on <= 1'b0;
      follower_on <= 1'b0;
      contrast_value <= `CLCDP_RST_CONTRAST;
      amp_ratio_field <= `CLCDP_RST_RATIO;
    end
    else if (state_q == ST_INIT)
    begin
      bus_width_select <= 1'b1;
      line_count_select <= 1'b0;
      tall_font_select <= 1'b0;
      instr_table_select <= 1'b0;
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      entry_increment <= 1'b1;
      entry_shift <= 1'b0;
      osc_adjust_field <= `CLCDP_RST_OSC;
      bias_select <= 1'b0;
      icon_on <= 1'b0;
      booster_on <= 1'b0;
      follower_on <= 1'b0;
      contrast_value <= `CLCDP_RST_CONTRAST;
      amp_ratio_field <= `CLCDP_RST_RATIO;
    end
    else if (fifo_pop && !head[8])
    begin
      if (hb[7:5] == `CLCDP_OP_FUNC)
      begin
        bus_width_select <= hb[4];
        line_count_select <= hb[3];
        tall_font_select <= hb[2];
        instr_table_select <= hb[0];
      end
      else if (hb == `CLCDP_OP_CLEAR)
        entry_increment <= 1'b1; // clear also forces increment
      else if (hb[7:3] == `CLCDP_OP_DISP)
      begin
        display_on <= hb[2];
        cursor_on <= hb[1];
        blink_on <= hb[0];
      end
      else if (hb[7:2] == `CLCDP_OP_ENTRY)
      begin
        entry_increment <= hb[1];
        entry_shift <= hb[0];
      end
      else if (ext_ok && hb[7:4] == `CLCDP_OP_OSC)
      begin
        bias_select <= hb[3];
        osc_adjust_field <= hb[2:0];
      end
      else if (ext_ok && hb[7:4] == `CLCDP_OP_POWER)
      begin
        icon_on <= hb[3];
        if (straps_low)
        begin
          booster_on <= hb[2];
          contrast_value[5:4] <= hb[1:0];
        end
      end
      else if (ext_ok && hb[7:4] == `CLCDP_OP_FOLLOW && straps_low)
      begin
        follower_on <= hb[3];
        amp_ratio_field <= hb[2:0];
      end
      else if (ext_ok && hb[7:4] == `CLCDP_OP_CONTR && straps_low)
        contrast_value[3:0] <= hb[3:0];
    end
  end

  // address counter: set address, step on data writes, zero on clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      address_counter <= '0;
      clear_display <= 1'b0;
    end
    else
    begin
      // held pin keeps cnt at zero, so pulse only once the pin is released
      clear_display <= (state_q == ST_INIT && cnt_q == '0 && xrst_n_s) | (fifo_pop & is_clear);
      if (state_q == ST_INIT || (fifo_pop && is_clear))
        address_counter <= '0;
      else if (fifo_pop && head[8])
        address_counter <= ac_step(address_counter, entry_increment);
      else if (fifo_pop && hb[7] == `CLCDP_OP_DDRAM)
        address_counter <= hb[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path: status byte, or two nibbles in 4-bit mode
  logic [7:0] status_w;
  assign status_w = {busy_flag, address_counter};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      db_out <= 8'h00;
      db_oe <= 8'h00;
    end
    else if (par_mode && e_s && rw_s)
    begin
      // data reads return zero: no display memory here
      if (e_rise)
      begin
        if (bus_width_select)
          db_out <= rs_s ? 8'h00 : status_w;
        else if (!nib_phase_q)
          db_out <= {rs_s ? 4'h0 : status_w[7:4], 4'h0};
        else
          db_out <= {rs_s ? 4'h0 : status_w[3:0], 4'h0};
      end
      db_oe <= bus_width_select ? 8'hFF : 8'hF0;
    end
    else
      db_oe <= 8'h00;
  end

endmodule
`default_nettype wire

// ==== tb/clcdp_host_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module clcdp_host_port_asserts
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ext_reset_pin_n,
  input wire logic option_strap_one,
  input wire logic option_strap_two,
  input wire logic [1:0] bus_mode,
  input wire logic e_strobe,
  input wire logic read_write,
  input wire logic [7:0] db_oe,
  input wire logic busy_flag,
  input wire logic bus_width_select,
  input wire logic line_count_select,
  input wire logic tall_font_select,
  input wire logic instr_table_select,
  input wire logic display_on,
  input wire logic cursor_on,
  input wire logic blink_on,
  input wire logic entry_increment,
  input wire logic entry_shift,
  input wire logic clear_display,
  input wire clcdp_pkg::clcdp_osc_t osc_adjust_field,
  input wire logic bias_select,
  input wire logic icon_on,
  input wire logic booster_on,
  input wire logic follower_on,
  input wire clcdp_pkg::clcdp_contrast_t contrast_value,
  input wire clcdp_pkg::clcdp_ratio_t amp_ratio_field
);
  import clcdp_pkg::*;
  logic strap_off;
  // straps not both low, so the gated fields must hold
  assign strap_off = option_strap_one | option_strap_two;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // eight-cycle windows leave room for the two-stage strap sync
  AST_POR_BUSY: assert property ($rose(rst_n) |-> busy_flag [*8])
    else $error("busy dropped early in init");
  // pin passes two syncs, then state, then the busy register: five samples
  AST_EXT_BUSY: assert property (!ext_reset_pin_n [*5] |-> busy_flag)
    else $error("busy low under external reset");
  AST_POR_POWER: assert property ($rose(rst_n) |->
    contrast_value == 6'h20 && amp_ratio_field == 3'h2 && osc_adjust_field == 3'h4 &&
    !(follower_on | booster_on | icon_on | bias_select))
    else $error("power defaults wrong after reset");
  AST_POR_CLEAR: assert property ($rose(rst_n) |=> clear_display ##1 !clear_display)
    else $error("no single clear pulse at init");
  AST_POR_MODE: assert property ($rose(rst_n) |->
    bus_width_select && entry_increment && !(line_count_select | tall_font_select |
    instr_table_select | display_on | cursor_on | blink_on | entry_shift))
    else $error("mode defaults wrong after reset");
  AST_STRAP_FOLLOW: assert property ((strap_off && ext_reset_pin_n) [*8] |=>
    $stable(follower_on) && $stable(amp_ratio_field))
    else $error("follower fields moved with straps off");
  AST_STRAP_CONTRAST: assert property ((strap_off && ext_reset_pin_n) [*8] |=>
    $stable(contrast_value) && $stable(booster_on))
    else $error("contrast or booster moved with straps off");
  AST_TABLE_GATE: assert property ((!instr_table_select && ext_reset_pin_n) [*8] |=>
    $stable(contrast_value) && $stable(follower_on) && $stable(amp_ratio_field))
    else $error("extension field moved in basic table");
  AST_WRITE_BUSY: assert property (bus_mode == 2'h0 && bus_width_select &&
    $fell(e_strobe) && !read_write |-> ##[1:8] busy_flag)
    else $error("no busy after a parallel write");
  AST_OE_WIDTH: assert property (db_oe != 8'h00 |->
    db_oe == (bus_width_select ? 8'hFF : 8'hF0))
    else $error("read drive width wrong");
endmodule
bind clcdp_host_port clcdp_host_port_asserts u_asserts
(
  .sys_clk, .rst_n, .ext_reset_pin_n, .option_strap_one, .option_strap_two,
  .bus_mode, .e_strobe, .read_write, .db_oe, .busy_flag, .bus_width_select,
  .line_count_select, .tall_font_select, .instr_table_select, .display_on,
  .cursor_on, .blink_on, .entry_increment, .entry_shift, .clear_display, .osc_adjust_field,
  .bias_select, .icon_on, .booster_on, .follower_on, .contrast_value, .amp_ratio_field
);
`default_nettype wire

// ==== tb/clcdp_host_bfm.sv ====
`timescale 1ns/1ps
`default_nettype none
module clcdp_host_bfm
(
  input wire logic sys_clk,
  input wire logic [7:0] db_out,
  input wire logic [7:0] db_oe,
  output logic e_strobe,
  output logic register_select,
  output logic read_write,
  output logic chip_select_low,
  output logic [7:0] db_in
);
  initial
  begin
    e_strobe = 1'b0;
    register_select = 1'b0;
    read_write = 1'b0;
    chip_select_low = 1'b1;
    db_in = 8'h00;
  end
  ////////////////////////////////////////
  // one strobe, E high then low four clocks; data held past the synced fall
  task automatic strobe(input logic rw, input logic rs, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    read_write = rw;
    register_select = rs;
    db_in = d;
    e_strobe = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    e_strobe = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    // hold over: show the inverse so stale data cannot pass
    db_in = ~d;
  endtask
  // high nibble first on the upper lines
  task automatic wr(input logic rs, input logic [7:0] b, input logic four);
    if (four)
    begin
      strobe(1'b0, rs, {b[7:4], ~b[3:0]});
      strobe(1'b0, rs, {b[3:0], b[7:4]});
    end
    else
      strobe(1'b0, rs, b);
  endtask
  // one nibble read, answer taken at the edge before E falls
  task automatic rd(output logic [7:0] v, output logic [7:0] oe);
    @(posedge sys_clk);
    #1;
    read_write = 1'b1;
    register_select = 1'b0;
    e_strobe = 1'b1;
    repeat (5) @(posedge sys_clk);
    v = db_out;
    oe = db_oe;
    #1;
    e_strobe = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    read_write = 1'b0;
  endtask
  // select low first, clock idles low outside frames, 800 ns period
  task automatic ser(input logic rs, input logic [7:0] b);
    db_in = 8'h00;
    #100;
    register_select = rs;
    chip_select_low = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #400;
      db_in[7:6] = {1'b0, b[i]};
      #400;
      db_in[7] = 1'b1;
    end
    #400;
    db_in[7:6] = {1'b0, ~b[0]};
    chip_select_low = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import clcdp_pkg::*;
  logic sys_clk, rst_n, ext_reset_pin_n, option_strap_one, option_strap_two;
  logic [1:0] bus_mode;
  logic chip_select_low, e_strobe, register_select, read_write;
  logic [7:0] db_in, db_out, db_oe, b, v, oe;
  logic busy_flag, bus_width_select, line_count_select, tall_font_select, instr_table_select;
  logic display_on, cursor_on, blink_on, entry_increment, entry_shift, clear_display;
  logic bias_select, icon_on, booster_on, follower_on;
  logic m_disp, m_dl, m_is, m_bias, m_ion, m_bon, m_fon;
  clcdp_addr_t address_counter;
  clcdp_osc_t osc_adjust_field, m_osc;
  clcdp_contrast_t contrast_value, m_c;
  clcdp_ratio_t amp_ratio_field, m_ratio;
  logic [18:0] obs;
  logic [31:0] seed;
  logic [7:0] boot [9];
  int fail_count, comparisons;
  // short counts keep init and clear brief
  clcdp_host_port #(.POR_CYCLES(50), .CLEAR_CYCLES(20)) u_dut
  (
    .sys_clk, .rst_n, .ext_reset_pin_n, .option_strap_one, .option_strap_two, .bus_mode,
    .chip_select_low, .e_strobe, .register_select, .read_write, .db_in, .db_out, .db_oe,
    .busy_flag, .address_counter, .bus_width_select, .line_count_select, .tall_font_select,
    .instr_table_select, .display_on, .cursor_on, .blink_on, .entry_increment, .entry_shift,
    .clear_display, .osc_adjust_field, .bias_select, .icon_on, .booster_on, .follower_on,
    .contrast_value, .amp_ratio_field
  );
  clcdp_host_bfm u_host
  (
    .sys_clk, .db_out, .db_oe, .e_strobe, .register_select, .read_write,
    .chip_select_low, .db_in
  );
  assign obs = {display_on, bus_width_select, instr_table_select, osc_adjust_field,
    bias_select, icon_on, booster_on, follower_on, amp_ratio_field, contrast_value};
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [18:0] want();
    return {m_disp, m_dl, m_is, m_osc, m_bias, m_ion, m_bon, m_fon, m_ratio, m_c};
  endfunction
  task automatic mreset();
    {m_disp, m_dl, m_is, m_osc, m_bias, m_ion, m_bon, m_fon} = {3'h2, 3'h4, 4'h0};
    {m_ratio, m_c} = {3'h2, 6'h20};
  endtask
  // expected effect of one instruction; gated fields need both straps low
  task automatic model(input logic [7:0] x);
    logic sl;
    sl = !option_strap_one && !option_strap_two;
    if (x[7:5] == 3'h1)
      {m_dl, m_is} = {x[4], x[0]};
    else if (x[7:3] == 5'h01)
      m_disp = x[2];
    else if (m_is && x[7:4] == 4'h1)
      {m_bias, m_osc} = x[3:0];
    else if (m_is && x[7:4] == 4'h5)
    begin
      m_ion = x[3];
      if (sl)
        {m_bon, m_c[5:4]} = x[2:0];
    end
    else if (m_is && sl && x[7:4] == 4'h6)
      {m_fon, m_ratio} = x[3:0];
    else if (m_is && sl && x[7:4] == 4'h7)
      m_c[3:0] = x[3:0];
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic miss(input string s);
    fail_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp)
      miss($sformatf("got %h want %h", got, exp));
  endtask
  // bounded wait for the device to finish; ends off the edge
  task automatic idle();
    int n;
    n = 0;
    repeat (7) @(posedge sys_clk);
    while (busy_flag !== 1'b0 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000)
      miss("busy never cleared");
    #1;
  endtask
  task automatic push(input logic [7:0] x, input logic [1:0] how);
    if (how == 2'h2)
      u_host.ser(1'b0, x);
    else
      u_host.wr(1'b0, x, how[0]);
    model(x);
  endtask
  task automatic cmd(input logic [7:0] x, input logic [1:0] how);
    push(x, how);
    idle();
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog sized well above the roughly 15000 cycles of traffic
  initial
  begin
    #(100 * 60000);
    miss("watchdog expired");
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial
  begin
    {fail_count, comparisons, seed} = {32'h0, 32'h0, 32'h125B93CB};
    // pin released and straps low, so bring-up reaches the gated fields
    {rst_n, ext_reset_pin_n, option_strap_one, option_strap_two, bus_mode} = 6'h10;
    boot = '{8'h38, 8'h39, 8'h14, 8'h78, 8'h5E, 8'h6A, 8'h0C, 8'h01, 8'h06};
    mreset();
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
    chk({busy_flag, obs}, {1'b1, want()});
    idle();
    done("power-on");
    foreach (boot[i])
      cmd(boot[i], 2'h0);
    chk({busy_flag, obs}, {1'b0, want()});
    done("bring-up");
    // random straps and extension commands, with table switches among them
    repeat (24)
    begin
      seed = xorshift(seed);
      {option_strap_one, option_strap_two} = {seed[0] & seed[2], seed[1] & seed[3]};
      repeat (4) @(posedge sys_clk);
      b = (seed[6:5] == 2'h0) ? {7'h1C, seed[7]} : {2'h1, seed[6:5], seed[11:8]};
      cmd(b, 2'h0);
      chk({busy_flag, obs}, {1'b0, want()});
    end
    done("random");
    {option_strap_one, option_strap_two} = 2'h0;
    seed = xorshift(seed);
    push(8'h39, 2'h0);
    push({4'h6, seed[3:0]}, 2'h0);
    push({4'h7, seed[7:4]}, 2'h0);
    idle();
    chk({busy_flag, obs}, {1'b0, want()});
    done("back-to-back");
    cmd(8'h80, 2'h0);
    cmd(8'h28, 2'h0);
    cmd(8'h29, 2'h1);
    cmd({4'h6, seed[11:8]}, 2'h1);
    push({4'h7, seed[15:12]}, 2'h1);
    u_host.rd(v, oe);
    chk({8'h00, v[7:4], oe}, {12'h008, 8'hF0});
    u_host.rd(v, oe);
    chk({8'h00, v[7:4], oe}, {12'h000, 8'hF0});
    idle();
    cmd(8'h39, 2'h1);
    chk({busy_flag, obs}, {1'b0, want()});
    done("nibble");
    bus_mode = 2'h1;
    cmd(8'h38, 2'h2);
    cmd(8'h39, 2'h2);
    cmd({4'h7, seed[19:16]}, 2'h2);
    cmd({4'h6, seed[23:20]}, 2'h2);
    chk({busy_flag, obs}, {1'b0, want()});
    bus_mode = 2'h0;
    done("serial");
    ext_reset_pin_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    ext_reset_pin_n = 1'b1;
    mreset();
    idle();
    chk({busy_flag, obs}, {1'b0, want()});
    done("external reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
